// ===== rtl/strap_regs.svh
// offsets, field positions, reset values and fixed codes of the supervisor trap state registers
// assumes: included by the modules by bare name; the package does not include it
`ifndef STRAP_REGS_SVH
`define STRAP_REGS_SVH
`define CSR_SCRATCH_ADDR 12'h140
`define CSR_TRAP_PC_ADDR 12'h141
`define CSR_TRAP_CAUSE_ADDR 12'h142
`define CSR_TRAP_VALUE_ADDR 12'h143
`define CAUSE_CODE_BITS 5
`define INT_SUP_SOFTWARE 5'h01
`define INT_SUP_TIMER 5'h05
`define INT_SUP_EXTERNAL 5'h09
`define INT_COUNTER_OVF 5'h0d
`define EXC_FETCH_MISALIGNED 5'h00
`define EXC_FETCH_ACCESS 5'h01
`define EXC_ILLEGAL 5'h02
`define EXC_BREAKPOINT 5'h03
`define EXC_LOAD_MISALIGNED 5'h04
`define EXC_LOAD_ACCESS 5'h05
`define EXC_STORE_MISALIGNED 5'h06
`define EXC_STORE_ACCESS 5'h07
`define EXC_ECALL_USER 5'h08
`define EXC_ECALL_SUPER 5'h09
`define EXC_FETCH_PAGE 5'h0c
`define EXC_LOAD_PAGE 5'h0d
`define EXC_STORE_PAGE 5'h0f
`define EXC_SOFTWARE_CHECK 5'h12
`define EXC_HARDWARE_ERROR 5'h13
`define SWCHK_NONE 2'h0
`define SWCHK_LANDING_PAD 2'h2
`define SWCHK_SHADOW_STACK 2'h3
`define RESET_WORD 64'h0000_0000_0000_0000
`endif

// ===== rtl/strap_pkg.sv
// types shared by the supervisor trap state register files
// assumes: nothing beyond a standard SystemVerilog tool
package strap_pkg;
	typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_SET, OP_CLEAR} csr_op_type;
	typedef enum logic [1:0] {TV_ZERO, TV_ADDRESS, TV_INSTR, TV_SUBCAUSE} tval_kind_type;
endpackage

// ===== rtl/trap_cause_legalize.sv
// legalizes a cause value: interrupt flag plus a code kept in the implemented low bits
// assumes: purely combinational, used for both software writes and hardware traps
`timescale 1ns/1ps
`default_nettype none
`include "strap_regs.svh"
module trap_cause_legalize #(
	parameter int WordWidth = 64,
	parameter int CodeBits = `CAUSE_CODE_BITS
) (
	input wire logic [WordWidth-1:0] rawCause, // value offered for storage
	output logic [WordWidth-1:0] legalCause // interrupt flag and stored code bits
);
	// codes wider than the implemented field are truncated, a legal write_legal_read_legal outcome
	always_comb begin
		legalCause = '0;
		legalCause[WordWidth-1] = rawCause[WordWidth-1];
		legalCause[CodeBits-1:0] = rawCause[CodeBits-1:0];
	end
endmodule
`default_nettype wire

// ===== rtl/trap_value_select.sv
// forms the trap value written on trap entry from the core's trap information
// assumes: core reports the kind of value and the raw address or instruction bits
`timescale 1ns/1ps
`default_nettype none
`include "strap_regs.svh"
module trap_value_select
	import strap_pkg::*;
#(
	parameter int WordWidth = 64,
	parameter int MaxInstrLen = 32
) (
	input wire tval_kind_type kind, // what the trap value carries
	input wire logic [WordWidth-1:0] faultAddr, // faulting portion virtual address
	input wire logic [WordWidth-1:0] instrBits, // faulting instruction, right justified
	input wire logic [1:0] subCause, // software check sub-cause
	output logic [WordWidth-1:0] value // value for the trap value register
);
	localparam int KeepBits = (MaxInstrLen < WordWidth) ? MaxInstrLen : WordWidth;
	always_comb begin
		value = '0;
		case (kind)
			TV_ADDRESS: value = faultAddr;
			TV_INSTR: value[KeepBits-1:0] = instrBits[KeepBits-1:0];
			TV_SUBCAUSE: value[1:0] = subCause;
			default: value = '0;
		endcase
	end
endmodule
`default_nettype wire

// ===== rtl/supervisor_trap_state_regs.sv
// supervisor scratch, trap pc, trap cause and trap value registers of one hart
// assumes: core issues one csr access or one trap per enabled cycle, trap wins
`timescale 1ns/1ps
`default_nettype none
`include "strap_regs.svh"
module supervisor_trap_state_regs
	import strap_pkg::*;
#(
	parameter int WordWidth = 64,
	parameter int MaxInstrLen = 32,
	parameter bit AlignSwitchable = 1'b1
) (
	input wire logic clk_sys, // core clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic clkEn, // freezes all state while low, except that reset still applies
	input wire logic csrValid, // one-cycle csr access request
	input wire csr_op_type csrOp, // write, set or clear; none is read only
	input wire logic [11:0] csrAddr, // csr address
	input wire logic [WordWidth-1:0] csrWdata, // write operand
	input wire logic align32, // current instruction_alignment is 32
	input wire logic trapTake, // one-cycle trap commit into supervisor
	input wire logic [WordWidth-1:0] trapPc, // interrupted instruction address
	input wire logic trapIsInterrupt, // trap was an interrupt
	input wire logic [`CAUSE_CODE_BITS-1:0] trapCode, // cause code
	input wire tval_kind_type trapValueKind, // kind of trap value
	input wire logic [WordWidth-1:0] trapFaultAddr, // faulting portion address
	input wire logic [WordWidth-1:0] trapInstrBits, // faulting instruction bits
	input wire logic [1:0] trapSubCause, // software check sub-cause
	output logic csrReady, // one-cycle answer pulse
	output logic csrHit, // address decoded to this block
	output logic [WordWidth-1:0] csrRdata, // read data, old value
	output logic [WordWidth-1:0] returnPc // trap pc as seen by supervisor_trap_return
);
	typedef struct packed {
		logic [WordWidth-1:0] scratch;
		logic [WordWidth-1:0] trapPcReg;
		logic [WordWidth-1:0] cause;
		logic [WordWidth-1:0] tval;
		logic ready;
		logic hit;
		logic [WordWidth-1:0] rdata;
		logic [WordWidth-1:0] retPc;
	} state_type;

	state_type cur, next_cur;
	logic [WordWidth-1:0] legalCause, newTval, causeRaw, trapCauseRaw, trapCauseLegal;

	// read view of the trap pc under the current alignment
	function automatic logic [WordWidth-1:0] pcView(input logic [WordWidth-1:0] v, input logic a32);
		logic [WordWidth-1:0] r;
		r = v;
		r[0] = 1'b0;
		if (a32 || !AlignSwitchable) begin
			r[1] = 1'b0;
		end
		return r;
	endfunction

	function automatic logic [WordWidth-1:0] applyOp(input csr_op_type op,
			input logic [WordWidth-1:0] old, input logic [WordWidth-1:0] d);
		logic [WordWidth-1:0] r;
		r = old;
		case (op)
			OP_WRITE: r = d;
			OP_SET: r = old | d;
			OP_CLEAR: r = old & ~d;
			default: r = old;
		endcase
		return r;
	endfunction

	function automatic logic isMine(input logic [11:0] a);
		logic r;
		r = 1'b0;
		if (a == `CSR_SCRATCH_ADDR) begin
			r = 1'b1;
		end else if (a == `CSR_TRAP_PC_ADDR) begin
			r = 1'b1;
		end else if (a == `CSR_TRAP_CAUSE_ADDR) begin
			r = 1'b1;
		end else if (a == `CSR_TRAP_VALUE_ADDR) begin
			r = 1'b1;
		end
		return r;
	endfunction

	always_comb begin
		causeRaw = applyOp(csrOp, cur.cause, csrWdata);
		trapCauseRaw = '0;
		trapCauseRaw[WordWidth-1] = trapIsInterrupt;
		trapCauseRaw[`CAUSE_CODE_BITS-1:0] = trapCode;
	end

	trap_cause_legalize #(.WordWidth(WordWidth), .CodeBits(`CAUSE_CODE_BITS)) swCauseLegal (
		.rawCause(causeRaw),
		.legalCause(legalCause)
	);

	trap_cause_legalize #(.WordWidth(WordWidth), .CodeBits(`CAUSE_CODE_BITS)) hwCauseLegal (
		.rawCause(trapCauseRaw),
		.legalCause(trapCauseLegal)
	);

	// core supplies faulting portion address, covering misaligned and fetch splits
	trap_value_select #(.WordWidth(WordWidth), .MaxInstrLen(MaxInstrLen)) tvalSel (
		.kind(trapValueKind),
		.faultAddr(trapFaultAddr),
		.instrBits(trapInstrBits),
		.subCause(trapSubCause),
		.value(newTval)
	);

	always_comb begin
		next_cur = cur;
		next_cur.ready = 1'b0;
		next_cur.hit = 1'b0;
		if (trapTake) begin
			// all three in one cycle so a handler read sees a matching set
			next_cur.trapPcReg = trapPc;
			next_cur.trapPcReg[0] = 1'b0;
			if (!AlignSwitchable) begin
				next_cur.trapPcReg[1] = 1'b0;
			end
			next_cur.cause = trapCauseLegal;
			next_cur.tval = newTval;
		end else if (csrValid) begin
			next_cur.ready = 1'b1;
			next_cur.hit = isMine(csrAddr);
			next_cur.rdata = '0;
			if (csrAddr == `CSR_SCRATCH_ADDR) begin
				next_cur.rdata = cur.scratch;
				next_cur.scratch = applyOp(csrOp, cur.scratch, csrWdata);
			end else if (csrAddr == `CSR_TRAP_PC_ADDR) begin
				next_cur.rdata = pcView(cur.trapPcReg, align32);
				next_cur.trapPcReg = applyOp(csrOp, cur.trapPcReg, csrWdata);
				next_cur.trapPcReg[0] = 1'b0;
				if (!AlignSwitchable) begin
					next_cur.trapPcReg[1] = 1'b0;
				end
			end else if (csrAddr == `CSR_TRAP_CAUSE_ADDR) begin
				next_cur.rdata = cur.cause;
				next_cur.cause = legalCause;
			end else if (csrAddr == `CSR_TRAP_VALUE_ADDR) begin
				next_cur.rdata = cur.tval;
				next_cur.tval = applyOp(csrOp, cur.tval, csrWdata);
			end
		end
		next_cur.retPc = pcView(next_cur.trapPcReg, align32);
		if (!rst_n) begin
			next_cur = '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (clkEn || !rst_n) begin
			cur <= next_cur;
		end
	end

	assign csrReady = cur.ready;
	assign csrHit = cur.hit;
	assign csrRdata = cur.rdata;
	assign returnPc = cur.retPc;

	// helper terms for the checks below
	logic swTaken, trapCommit;
	assign swTaken = clkEn && csrValid && !trapTake;
	assign trapCommit = clkEn && trapTake;
	localparam int InstrKeep = (MaxInstrLen < WordWidth) ? MaxInstrLen : WordWidth;

	// software access: each register against its own operation
	a_scratch_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_SCRATCH_ADDR && csrOp == OP_WRITE) |=> cur.scratch == $past(csrWdata))
		else $error("scratch write lost");
	a_scratch_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_SCRATCH_ADDR && csrOp == OP_SET) |=> cur.scratch == $past(cur.scratch | csrWdata))
		else $error("scratch set wrong");
	a_scratch_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_SCRATCH_ADDR && csrOp == OP_CLEAR) |=> cur.scratch == $past(cur.scratch & ~csrWdata))
		else $error("scratch clear wrong");
	a_scratch_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_SCRATCH_ADDR) |=> csrRdata == $past(cur.scratch))
		else $error("scratch read altered");
	a_scratch_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && !(swTaken && csrAddr == `CSR_SCRATCH_ADDR)) |=> $stable(cur.scratch))
		else $error("scratch changed without write");
	a_pc_write_value: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_PC_ADDR && csrOp == OP_WRITE) |=> cur.trapPcReg[WordWidth-1:2] == $past(csrWdata[WordWidth-1:2]))
		else $error("trap pc write lost");
	a_pc_bit_one_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_PC_ADDR && csrOp == OP_WRITE && AlignSwitchable) |=> cur.trapPcReg[1] == $past(csrWdata[1]))
		else $error("trap pc bit one not writable");
	// masking is on the read path only, so the stored bit survives a switch back to 16
	a_pc_read_view: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_PC_ADDR) |=> csrRdata[WordWidth-1:2] == $past(cur.trapPcReg[WordWidth-1:2])
		&& !csrRdata[0] && csrRdata[1] == ($past(cur.trapPcReg[1]) && !$past(align32) && AlignSwitchable))
		else $error("trap pc read view wrong");
	a_pc_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && !trapTake && !(swTaken && csrAddr == `CSR_TRAP_PC_ADDR)) |=> $stable(cur.trapPcReg))
		else $error("trap pc written without cause");
	a_return_pc_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
		returnPc[WordWidth-1:2] == cur.trapPcReg[WordWidth-1:2])
		else $error("return pc differs from trap pc");
	a_cause_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_CAUSE_ADDR && csrOp == OP_WRITE) |=> cur.cause[WordWidth-1] == $past(csrWdata[WordWidth-1])
		&& cur.cause[`CAUSE_CODE_BITS-1:0] == $past(csrWdata[`CAUSE_CODE_BITS-1:0])) else $error("cause write lost");
	a_cause_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_CAUSE_ADDR && csrOp == OP_SET) |=> cur.cause[`CAUSE_CODE_BITS-1:0] ==
		$past(cur.cause[`CAUSE_CODE_BITS-1:0] | csrWdata[`CAUSE_CODE_BITS-1:0])) else $error("cause set wrong");
	a_cause_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_CAUSE_ADDR && csrOp == OP_CLEAR) |=> cur.cause[`CAUSE_CODE_BITS-1:0] ==
		$past(cur.cause[`CAUSE_CODE_BITS-1:0] & ~csrWdata[`CAUSE_CODE_BITS-1:0])) else $error("cause clear wrong");
	a_cause_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_CAUSE_ADDR) |=> csrRdata == $past(cur.cause))
		else $error("cause read altered");
	// the middle bits are never stored, whatever software or the core offers
	a_cause_unused_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cur.cause[WordWidth-2:`CAUSE_CODE_BITS] == '0)
		else $error("unimplemented cause bits set");
	a_tval_sw_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_VALUE_ADDR && csrOp == OP_WRITE) |=> cur.tval == $past(csrWdata))
		else $error("trap value write lost");
	a_tval_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_VALUE_ADDR && csrOp == OP_SET) |=> cur.tval == $past(cur.tval | csrWdata))
		else $error("trap value set wrong");
	a_tval_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(swTaken && csrAddr == `CSR_TRAP_VALUE_ADDR) |=> csrRdata == $past(cur.tval))
		else $error("trap value read altered");

	// trap entry: all three registers from the one commit cycle
	a_trap_pc_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
		trapCommit |=> cur.trapPcReg == {$past(trapPc[WordWidth-1:2]), $past(trapPc[1]) && AlignSwitchable, 1'b0})
		else $error("trap pc not loaded");
	a_cause_int_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
		trapCommit |=> cur.cause[WordWidth-1] == $past(trapIsInterrupt))
		else $error("cause flag wrong");
	a_cause_code_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
		trapCommit |=> cur.cause[`CAUSE_CODE_BITS-1:0] == $past(trapCode))
		else $error("cause code wrong");
	a_tval_address: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trapCommit && trapValueKind == TV_ADDRESS) |=> cur.tval == $past(trapFaultAddr))
		else $error("trap value address wrong");
	a_tval_instr: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trapCommit && trapValueKind == TV_INSTR) |=> cur.tval == (($past(trapInstrBits) << (WordWidth - InstrKeep)) >> (WordWidth - InstrKeep)))
		else $error("trap value instruction bits wrong");
	a_tval_subcause: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trapCommit && trapValueKind == TV_SUBCAUSE) |=> cur.tval == {{(WordWidth-2){1'b0}}, $past(trapSubCause)})
		else $error("trap value sub-cause wrong");
	a_tval_zero_other: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(trapCommit && trapValueKind == TV_ZERO) |=> cur.tval == '0)
		else $error("trap value not zeroed");
	a_trap_drops_csr: assert property (@(posedge clk_sys) disable iff (!rst_n)
		trapCommit |=> !csrReady)
		else $error("access answered in trap cycle");

	// hold checks: no hardware write outside a trap, then trap pc bit zero and bit one masking
	a_cause_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && !trapTake && !(csrValid && csrAddr == `CSR_TRAP_CAUSE_ADDR)) |=> $stable(cur.cause))
		else $error("cause changed without cause");
	a_tval_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && !trapTake && !(csrValid && csrAddr == `CSR_TRAP_VALUE_ADDR)) |=> $stable(cur.tval))
		else $error("trap value changed");
	a_scratch_trap_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
		trapTake |=> $stable(cur.scratch))
		else $error("scratch touched by trap");
	a_pc_bit_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!cur.trapPcReg[0] && !returnPc[0])
		else $error("trap pc bit zero set");
	a_pc_align_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(clkEn && align32) |=> !returnPc[1])
		else $error("trap pc bit one visible");

	// answer pulse: one cycle per accepted access, none otherwise
	a_read_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		swTaken |=> csrReady ##1 (!csrReady || $past(csrValid)))
		else $error("no read answer");
	a_ready_only_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(rst_n && clkEn && !swTaken) |=> !csrReady)
		else $error("answer without access");
endmodule
`default_nettype wire

// ===== tb/core_trap_model.sv
// core side of the trap interface: turns one commit request into trap information
// assumes: bench raises fire for one cycle just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module core_trap_model
	import strap_pkg::*;
(
	input wire logic fire, // commit a trap now
	input wire logic isInt, // trap is an interrupt
	input wire logic [4:0] code, // cause code
	input wire tval_kind_type kind, // trap value kind
	input wire logic [63:0] pc, // instruction start
	input wire logic [63:0] fa, // faulting portion address
	input wire logic [63:0] ins, // fetched instruction window
	input wire logic [1:0] sub, // software check sub-cause
	output logic trapTake, // commit pulse
	output logic trapIsInterrupt, // interrupt flag
	output logic [4:0] trapCode, // cause code
	output tval_kind_type trapValueKind, // trap value kind
	output logic [63:0] trapPc, // interrupted instruction
	output logic [63:0] trapFaultAddr, // faulting portion
	output logic [63:0] trapInstrBits, // instruction bits
	output logic [1:0] trapSubCause // sub-cause
);
	always_comb begin
		trapTake = fire;
		trapIsInterrupt = isInt;
		trapCode = code;
		trapValueKind = kind;
		trapSubCause = sub;
		// idle pc, fault address and instruction lines flip so stale information never looks valid
		trapPc = fire ? pc : ~pc;
		trapFaultAddr = fire ? fa : ~fa;
		trapInstrBits = fire ? ins : ~ins;
	end
endmodule
`default_nettype wire

// ===== tb/test_supervisor_trap_state_regs.sv
// self-checking bench: reference model of the four registers against the design
// assumes: rtl/ compiled first, partner model in tb/core_trap_model.sv
`timescale 1ns/1ps
`default_nettype none
module test_supervisor_trap_state_regs;
	import strap_pkg::*;
	logic clk_sys, rst_n, clkEn, csrValid, align32, fire, isInt, trapTake, trapIsInterrupt, csrReady, csrHit;
	csr_op_type csrOp, op;
	tval_kind_type kind, trapValueKind;
	logic [11:0] csrAddr, a;
	logic [63:0] csrWdata, pc, fa, ins, seed, csrRdata, returnPc, trapPc, trapFaultAddr, trapInstrBits;
	logic [63:0] m [4];
	logic [4:0] code, trapCode;
	logic [1:0] sub, trapSubCause;
	logic [5:0] codes [19];
	int fail_count, num_checks;
	core_trap_model partner (.fire(fire), .isInt(isInt), .code(code), .kind(kind), .pc(pc), .fa(fa), .ins(ins),
		.sub(sub), .trapTake(trapTake), .trapIsInterrupt(trapIsInterrupt), .trapCode(trapCode),
		.trapValueKind(trapValueKind), .trapPc(trapPc), .trapFaultAddr(trapFaultAddr),
		.trapInstrBits(trapInstrBits), .trapSubCause(trapSubCause));
	supervisor_trap_state_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .csrValid(csrValid),
		.csrOp(csrOp), .csrAddr(csrAddr), .csrWdata(csrWdata), .align32(align32), .trapTake(trapTake),
		.trapPc(trapPc), .trapIsInterrupt(trapIsInterrupt), .trapCode(trapCode), .trapValueKind(trapValueKind),
		.trapFaultAddr(trapFaultAddr), .trapInstrBits(trapInstrBits), .trapSubCause(trapSubCause),
		.csrReady(csrReady), .csrHit(csrHit), .csrRdata(csrRdata), .returnPc(returnPc));
	function automatic logic [63:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 7;
		seed ^= seed << 17;
		return seed;
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		num_checks++;
		if (seen !== want) begin
			fail_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic csr(input csr_op_type o, input logic [11:0] ad, input logic [63:0] w);
		logic [63:0] old, nv;
		logic hit;
		hit = ad >= 12'h140 && ad <= 12'h143;
		old = hit ? m[ad[1:0]] : 64'h0;
		@(posedge clk_sys);
		csrValid <= 1'b1;
		csrOp <= o;
		csrAddr <= ad;
		csrWdata <= w;
		@(posedge clk_sys);
		csrValid <= 1'b0;
		#1;
		check(64'(csrReady), 64'h1);
		check(64'(csrHit), 64'(hit));
		check(csrRdata, (ad == 12'h141 && align32) ? old & ~64'h2 : old);
		nv = o == OP_WRITE ? w : o == OP_SET ? old | w : o == OP_CLEAR ? old & ~w : old;
		if (ad == 12'h141)
			nv[0] = 1'b0;
		if (ad == 12'h142)
			nv[62:5] = '0;
		if (hit)
			m[ad[1:0]] = nv;
	endtask
	task automatic read_all();
		for (int i = 0; i < 4; i++)
			csr(OP_NONE, 12'h140 + 12'(i), 64'h0);
	endtask
	task automatic trap(input logic [5:0] c);
		logic [1:0] s;
		s = 2'(rnd() % 3) + 2'h1;
		@(posedge clk_sys);
		fire <= 1'b1;
		isInt <= c[5];
		code <= c[4:0];
		kind <= c[5] ? TV_ZERO : c[4:0] == 5'h02 ? TV_INSTR : c[4:0] == 5'h12 ? TV_SUBCAUSE :
			c[4:0] inside {5'h08, 5'h09, 5'h13} ? TV_ZERO : TV_ADDRESS;
		pc <= rnd();
		fa <= rnd();
		ins <= rnd();
		sub <= s == 2'h1 ? 2'h0 : s;
		csrValid <= 1'b1;
		csrOp <= OP_WRITE;
		csrAddr <= 12'h140;
		csrWdata <= rnd();
		@(posedge clk_sys);
		fire <= 1'b0;
		csrValid <= 1'b0;
		#1;
		check(64'(csrReady), 64'h0);
		m[1] = pc & ~64'h1;
		m[2] = {isInt, 58'h0, code};
		m[3] = kind == TV_ADDRESS ? fa : kind == TV_INSTR ? {32'h0, ins[31:0]} : kind == TV_SUBCAUSE ? {62'h0, sub} : 64'h0;
		read_all();
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		#(20000 * 100);
		fail_count++;
		give_verdict();
	end
	initial begin
		{rst_n, csrValid, align32, fire, isInt, code, sub, csrAddr} = '0;
		{csrWdata, pc, fa, ins} = '0;
		clkEn = 1'b1;
		csrOp = OP_NONE;
		kind = TV_ZERO;
		m = '{default: 64'h0};
		fail_count = 0;
		num_checks = 0;
		seed = 64'h0000_0000_0000_004c;
		codes = '{6'h21, 6'h25, 6'h29, 6'h2d, 6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h08,
			6'h09, 6'h0c, 6'h0d, 6'h0f, 6'h12, 6'h13};
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		read_all();
		$display("test reset done");
		repeat (80) begin
			@(posedge clk_sys);
			#1;
			check(returnPc, m[1] & ~(align32 ? 64'h3 : 64'h1));
			@(posedge clk_sys);
			align32 <= seed[9];
			a = 12'h140 + 12'(rnd() % 5);
			op = csr_op_type'(rnd() % 4);
			if (a == 12'h141 && op > OP_WRITE)
				op = OP_WRITE;
			csr(op, a, rnd());
		end
		$display("test software access done");
		foreach (codes[i])
			trap(codes[i]);
		$display("test trap entry done");
		@(posedge clk_sys);
		clkEn <= 1'b0;
		csrValid <= 1'b1;
		csrOp <= OP_WRITE;
		csrAddr <= 12'h140;
		fire <= 1'b1;
		@(posedge clk_sys);
		clkEn <= 1'b1;
		csrValid <= 1'b0;
		fire <= 1'b0;
		read_all();
		$display("test freeze done");
		@(posedge clk_sys);
		rst_n <= 1'b0;
		@(posedge clk_sys);
		rst_n <= 1'b1;
		m = '{default: 64'h0};
		read_all();
		$display("test second reset done");
		give_verdict();
	end
endmodule
`default_nettype wire
